// ==== core/srs_synth_ctrl.sv ====
`timescale 1ns/1ps
module srs_synth_ctrl #(
  parameter int ERR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_enable,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  input wire logic ext_ref_input_pin,
  input wire logic pfd_valid,
  input wire logic [ERR_W-1:0] pfd_err_ns,
  input wire logic observe_pin_i,
  output logic regulator_enable,
  output logic regulator_ready,
  output logic xtal_osc_enable,
  output logic ext_ref_select,
  output logic divided_ref_output,
  output logic divided_ref_oe,
  output logic pfd_ref_pulse,
  output logic digital_lock,
  output logic vco_power,
  output logic vco_half_band,
  output logic pa_enable,
  output logic [23:0] modulation_settings,
  output logic observe_pin_o,
  output logic observe_pin_oe
);
  if (ERR_W < 5) begin : g_chk
    $error("pfd_err_ns too narrow for lock thresholds");
  end
  // the counters below are sized for the package values; refuse anything larger
  if (srs_pkg::REG_SETTLE_CYC < 1 || srs_pkg::REG_SETTLE_CYC > 2047) begin : g_settle_chk
    $error("settle count does not fit its counter");
  end
  if (srs_pkg::LOCK_COUNT < 1 || srs_pkg::LOCK_COUNT > 7) begin : g_count_chk
    $error("lock qualification count does not fit its counter");
  end
  // without hysteresis a jittery loop would toggle lock on every comparison
  if (srs_pkg::LOCK_CLR_NS <= srs_pkg::LOCK_SET_NS) begin : g_hyst_chk
    $error("lock clear threshold must lie above the set threshold");
  end

  // ************************************************
  // power and regulator
  // ************************************************
  // counts clk cycles from ce high until the supply is taken as settled
  // the counter parks at the top, so ready cannot wrap back low while ce holds
  localparam logic [10:0] SETTLE = 11'(srs_pkg::REG_SETTLE_CYC);
  logic [10:0] settle_q;
  logic ready_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regulator_enable <= 1'b0;
      settle_q <= 11'h000;
      ready_q <= 1'b0;
    end else begin
      regulator_enable <= chip_enable;
      if (!chip_enable) begin
        settle_q <= 11'h000;
        ready_q <= 1'b0;
      end else if (settle_q == SETTLE - 11'h001) begin
        ready_q <= 1'b1;
      end else begin
        settle_q <= settle_q + 11'h001;
      end
    end
  end
  assign regulator_ready = ready_q;

  // ************************************************
  // serial interface
  // ************************************************
  // no crossing: the link pins are sampled as ordinary synchronous inputs
  logic sclk_q, le_q;
  logic [23:0] shift_q;
  logic [23:0] ref_q, n_q, mod_q, func_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
      le_q <= 1'b0;
    end else begin
      sclk_q <= ser_clk;
      le_q <= load_strobe;
    end
  end

  // shifter is powered from the regulator, so it is dead until ready
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q <= 24'h000000;
    end else if (!ready_q || !chip_enable) begin
      shift_q <= 24'h000000;
    end else if (ser_clk && !sclk_q) begin
      shift_q <= {shift_q[22:0], ser_data};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_q <= srs_pkg::REF_RESET;
      n_q <= srs_pkg::N_RESET;
      mod_q <= srs_pkg::MOD_RESET;
      func_q <= srs_pkg::FUNC_RESET;
    end else if (!chip_enable) begin
      ref_q <= srs_pkg::REF_RESET;
      n_q <= srs_pkg::N_RESET;
      mod_q <= srs_pkg::MOD_RESET;
      func_q <= srs_pkg::FUNC_RESET;
    // latch only on the strobe's rising edge, so a held strobe loads once
    end else if (ready_q && load_strobe && !le_q) begin
      unique case (shift_q[1:0])
        srs_pkg::SEL_REF: ref_q <= shift_q;
        srs_pkg::SEL_N: n_q <= shift_q;
        srs_pkg::SEL_MOD: mod_q <= shift_q;
        srs_pkg::SEL_FUNC: func_q <= shift_q;
      endcase
    end
  end

  // ************************************************
  // reference source
  // ************************************************
  logic osc_off, osc_run, ext_q, ref_tick;
  assign osc_off = ref_q[srs_pkg::REF_OSC_OFF_BIT];
  // the crystal has no enable register of its own: ce low or the osc-off bit stops it
  assign osc_run = chip_enable;
  // external reference ticks on its own rising edge; crystal ticks every clk
  assign ref_tick = osc_run && (osc_off ? (ext_ref_input_pin && !ext_q) : 1'b1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_q <= 1'b0;
      xtal_osc_enable <= 1'b0;
      ext_ref_select <= 1'b0;
    end else begin
      ext_q <= ext_ref_input_pin;
      xtal_osc_enable <= osc_run && !osc_off;
      ext_ref_select <= osc_off;
    end
  end

  // ************************************************
  // divided reference output
  // ************************************************
  // half period in ref ticks; ratio 2*k, nibble 0 is served as k=1
  logic [3:0] half_q, hcnt_q, new_half;
  logic div_q;
  assign new_half = (ref_q[srs_pkg::REF_CLKDIV_LSB +: 4] == 4'h0) ? 4'h1
                    : ref_q[srs_pkg::REF_CLKDIV_LSB +: 4];

  // ratio swaps only at a toggle, so no runt half-period reaches the pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_q <= srs_pkg::REF_RESET[srs_pkg::REF_CLKDIV_LSB +: 4];
      hcnt_q <= 4'h0;
      div_q <= 1'b0;
    end else if (ref_tick) begin
      if (hcnt_q == half_q - 4'h1) begin
        hcnt_q <= 4'h0;
        div_q <= !div_q;
        half_q <= new_half;
      end else begin
        hcnt_q <= hcnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divided_ref_output <= 1'b0;
      divided_ref_oe <= 1'b0;
    end else begin
      divided_ref_output <= div_q;
      divided_ref_oe <= func_q[srs_pkg::FN_DIVIDED_REF_OUTPUT_EN_BIT] && chip_enable;
    end
  end

  // ************************************************
  // reference counter
  // ************************************************
  logic [3:0] rcnt_q, rdiv;
  assign rdiv = (ref_q[srs_pkg::REF_RDIV_LSB +: 4] == 4'h0) ? 4'h1
                : ref_q[srs_pkg::REF_RDIV_LSB +: 4];

  // compare with >= so a smaller ratio landing mid-count recovers at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rcnt_q <= 4'h0;
      pfd_ref_pulse <= 1'b0;
    end else if (ref_tick && rcnt_q >= rdiv - 4'h1) begin
      rcnt_q <= 4'h0;
      pfd_ref_pulse <= 1'b1;
    end else begin
      if (ref_tick) begin
        rcnt_q <= rcnt_q + 4'h1;
      end
      pfd_ref_pulse <= 1'b0;
    end
  end

  // ************************************************
  // lock detect
  // ************************************************
  localparam logic [ERR_W-1:0] SET_NS = ERR_W'(srs_pkg::LOCK_SET_NS);
  localparam logic [ERR_W-1:0] CLR_NS = ERR_W'(srs_pkg::LOCK_CLR_NS);
  localparam logic [2:0] NEED = 3'(srs_pkg::LOCK_COUNT);
  // set below 15 ns, clear only at 25 ns: jitter between the two keeps lock
  logic [2:0] good_q;
  logic lock_q, ana_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      good_q <= 3'h0;
      lock_q <= 1'b0;
    end else if (!chip_enable) begin
      good_q <= 3'h0;
      lock_q <= 1'b0;
    end else if (pfd_valid) begin
      if (!lock_q) begin
        if (pfd_err_ns >= SET_NS) begin
          good_q <= 3'h0;
        end else if (good_q == NEED - 3'h1) begin
          good_q <= 3'h0;
          lock_q <= 1'b1;
        end else begin
          good_q <= good_q + 3'h1;
        end
      end else if (pfd_err_ns >= CLR_NS) begin
        lock_q <= 1'b0;
      end
    end
  end

  // a comparison with any residual error pulls the line low for one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ana_q <= 1'b0;
    end else begin
      ana_q <= lock_q && !(pfd_valid && pfd_err_ns != '0);
    end
  end
  assign digital_lock = lock_q;

  // ************************************************
  // observe pin
  // ************************************************
  logic [3:0] obs_sel;
  logic obs_d, obs_oe_d;
  assign obs_sel = func_q[srs_pkg::FN_OBS_LSB +: 4];

  // registered below, so the pin never glitches while the select field changes
  always_comb begin
    obs_d = 1'b0;
    obs_oe_d = 1'b1;
    case (obs_sel)
      srs_pkg::OBS_HIGH: obs_d = 1'b1;
      srs_pkg::OBS_TRISTATE: obs_oe_d = 1'b0;
      srs_pkg::OBS_REG_READY: obs_d = ready_q;
      srs_pkg::OBS_DIG_LOCK: obs_d = lock_q;
      srs_pkg::OBS_ANA_LOCK: obs_oe_d = !ana_q;
      srs_pkg::OBS_R_DIV: obs_d = pfd_ref_pulse;
      srs_pkg::OBS_DIVIDED_REF_OUTPUT: obs_d = div_q;
      default: obs_d = 1'b0;
    endcase
  end

  // pin reads low while ce is low: nothing behind it is powered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      observe_pin_o <= 1'b0;
      observe_pin_oe <= 1'b1;
    end else begin
      observe_pin_o <= obs_d && chip_enable;
      observe_pin_oe <= obs_oe_d || !chip_enable;
    end
  end

  // ************************************************
  // vco and misc controls
  // ************************************************
  // one flop per control keeps every pin free of decode glitches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vco_power <= 1'b0;
      vco_half_band <= 1'b0;
      pa_enable <= 1'b0;
      modulation_settings <= srs_pkg::MOD_RESET;
    end else begin
      vco_power <= func_q[srs_pkg::FN_VCO_POWER_BIT] && chip_enable;
      vco_half_band <= n_q[srs_pkg::N_HALF_BAND_BIT];
      pa_enable <= func_q[srs_pkg::FN_PA_EN_BIT] && chip_enable;
      modulation_settings <= mod_q;
    end
  end

  // observe_pin_i is the wired level; the block itself never needs it back
  logic unused_obs;
  assign unused_obs = observe_pin_i;
endmodule

// ==== pkg/srs_pkg.sv ====
// Operation
// - crystal runs unless osc-off high; else external
// - oscillator on after power-up, off when ce low
// - divided output 50:50, even ratio 2..30
// - output ratio from reference register bits 21:18
// - divided output ratio sixteen after power-up
// - function bit 4 enables output buffer, default high
// - reference counter divides by 1..15 for detector
// - reference count defaults to one
// - four-bit function field selects observe pin source
// - observe pin shows regulator ready by default
// - lock set after five errors below 15 ns
// - lock held until 25 ns error seen
// - analog lock: open-drain high, brief low pulses
// - ce low stops regulator, registers revert to defaults
// - vco powered only while power bit set
// - half-band bit inserts divide-by-two after vco
// - 24-bit word msb first, sampled on clock rise
// - load strobe rise latches word by two lsbs
package srs_pkg;
  localparam int WORD_W = 24;
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_N = 2'h1;
  localparam logic [1:0] SEL_MOD = 2'h2;
  localparam logic [1:0] SEL_FUNC = 2'h3;
  localparam logic [23:0] REF_RESET = 24'h202000;
  localparam logic [23:0] N_RESET = 24'h202001;
  localparam logic [23:0] MOD_RESET = 24'h800602;
  localparam logic [23:0] FUNC_RESET = 24'h0018D3;
  localparam int REF_CLKDIV_LSB = 18;
  localparam int REF_OSC_OFF_BIT = 17;
  localparam int REF_RDIV_LSB = 13;
  localparam int N_HALF_BAND_BIT = 22;
  localparam int FN_OBS_LSB = 11;
  localparam int FN_DIVIDED_REF_OUTPUT_EN_BIT = 4;
  localparam int FN_PA_EN_BIT = 3;
  localparam int FN_VCO_POWER_BIT = 2;
  localparam logic [3:0] OBS_LOW = 4'h0;
  localparam logic [3:0] OBS_HIGH = 4'h1;
  localparam logic [3:0] OBS_TRISTATE = 4'h2;
  localparam logic [3:0] OBS_REG_READY = 4'h3;
  localparam logic [3:0] OBS_DIG_LOCK = 4'h4;
  localparam logic [3:0] OBS_ANA_LOCK = 4'h5;
  localparam logic [3:0] OBS_R_DIV = 4'h6;
  localparam logic [3:0] OBS_DIVIDED_REF_OUTPUT = 4'h7;
  localparam int CLK_MHZ = 25;
  localparam int REG_SETTLE_US = 50;
  localparam int REG_SETTLE_CYC = REG_SETTLE_US * CLK_MHZ;
  localparam int LOCK_SET_NS = 15;
  localparam int LOCK_CLR_NS = 25;
  localparam int LOCK_COUNT = 5;
endpackage

// ==== tb/srs_host.sv ====
`timescale 1ns/1ps
module srs_host (
  input wire logic clk,
  input wire logic reg_ready,
  input wire logic go,
  input wire logic [23:0] word,
  output logic ser_clk,
  output logic ser_data,
  output logic load_strobe,
  output logic busy
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      // never program before the regulator is up
      if (go && reg_ready) begin
        @(negedge clk);
        busy = 1'b1;
        for (int i = 23; i >= 0; i--) begin
          ser_data = word[i];
          repeat (2) @(negedge clk);
          ser_clk = 1'b1;
          repeat (2) @(negedge clk);
          ser_clk = 1'b0;
        end
        ser_data = ~ser_data;
        load_strobe = 1'b1;
        repeat (2) @(negedge clk);
        load_strobe = 1'b0;
        busy = 1'b0;
      end
    end
  end
endmodule

// ==== tb/srs_synth_ctrl_chk.sv ====
`timescale 1ns/1ps
module srs_synth_ctrl_chk #(parameter int ERR_W = 8) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_enable,
  input wire logic pfd_valid,
  input wire logic [ERR_W-1:0] pfd_err_ns,
  input wire logic regulator_enable,
  input wire logic regulator_ready,
  input wire logic xtal_osc_enable,
  input wire logic ext_ref_select,
  input wire logic digital_lock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_big;
    pfd_valid && pfd_err_ns >= 25;
  endsequence
  sequence s_mid;
    pfd_valid && pfd_err_ns >= 15;
  endsequence
  chk_reg_follows_ce: assert property (chip_enable |=> regulator_enable)
    else $error("regulator off with ce high");
  chk_ce_clears_all: assert property (!chip_enable |=> !regulator_ready && !digital_lock)
    else $error("state kept with ce low");
  chk_ce_stops_osc: assert property (!chip_enable |=> !xtal_osc_enable)
    else $error("oscillator on with ce low");
  chk_osc_or_ext: assert property (xtal_osc_enable |-> !ext_ref_select)
    else $error("crystal and external both on");
  chk_lock_drop: assert property (digital_lock ##0 s_big |=> !digital_lock)
    else $error("lock kept after large error");
  chk_lock_hold: assert property (digital_lock && chip_enable && !(pfd_valid && pfd_err_ns >= 25)
    |=> digital_lock)
    else $error("lock lost without cause");
  chk_lock_rise: assert property ($rose(digital_lock) |-> $past(pfd_valid) && $past(pfd_err_ns) < 15)
    else $error("lock set without good compare");
  chk_no_early_lock: assert property (!digital_lock ##0 s_mid |=> !digital_lock)
    else $error("lock set on bad compare");
endmodule
bind srs_synth_ctrl srs_synth_ctrl_chk #(.ERR_W(ERR_W)) u_chk (.clk, .rst, .chip_enable, .pfd_valid,
  .pfd_err_ns, .regulator_enable, .regulator_ready, .xtal_osc_enable, .ext_ref_select, .digital_lock);

// ==== tb/synth_reference_and_status_control_test.sv ====
`timescale 1ns/1ps
module synth_reference_and_status_control_test;
  logic clk, rst, ce, pfd_valid, go, sck, sda, ld, busy;
  logic ext_ref = 1'b0;
  logic [7:0] pfd_err;
  logic [23:0] word, mod_q;
  logic reg_en, rdy, xo, xsel, dro, droe, rpul, lock, vco, hb, pa, obs_o, obs_oe, obs;
  int err_total, n_checks, h, p;
  assign obs = obs_oe ? obs_o : 1'b1;
  srs_synth_ctrl dut (.clk(clk), .rst(rst), .chip_enable(ce), .ser_clk(sck), .ser_data(sda),
    .load_strobe(ld), .ext_ref_input_pin(ext_ref), .pfd_valid(pfd_valid), .pfd_err_ns(pfd_err),
    .observe_pin_i(obs), .regulator_enable(reg_en), .regulator_ready(rdy), .xtal_osc_enable(xo),
    .ext_ref_select(xsel), .divided_ref_output(dro), .divided_ref_oe(droe), .pfd_ref_pulse(rpul),
    .digital_lock(lock), .vco_power(vco), .vco_half_band(hb), .pa_enable(pa),
    .modulation_settings(mod_q), .observe_pin_o(obs_o), .observe_pin_oe(obs_oe));
  srs_host host (.clk(clk), .reg_ready(rdy), .go(go), .word(word), .ser_clk(sck), .ser_data(sda),
    .load_strobe(ld), .busy(busy));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) ext_ref <= ~ext_ref;
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang;
    err_total++;
    stop_test;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
    if (n >= 2000) hang;
    repeat (2) @(negedge clk);
  endtask
  task automatic wr(input logic [23:0] w);
    int n;
    word = w;
    go = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 50) begin @(posedge clk); n++; end
    @(negedge clk);
    go = 1'b0;
    while (busy !== 1'b0 && n < 300) begin @(posedge clk); n++; end
    if (n >= 300 || n == 50) hang;
    repeat (3) @(negedge clk);
  endtask
  task automatic period(input bit s);
    int n;
    n = 0;
    while ((s ? rpul : dro) !== 1'b0 && n < 99) begin @(negedge clk); n++; end
    while ((s ? rpul : dro) !== 1'b1 && n < 99) begin @(negedge clk); n++; end
    h = 0;
    p = 0;
    while ((s ? rpul : dro) === 1'b1 && p < 99) begin @(negedge clk); h++; p++; end
    while ((s ? rpul : dro) === 1'b0 && p < 99) begin @(negedge clk); p++; end
    if (n >= 99 || p >= 99) hang;
  endtask
  task automatic cmp(input logic [7:0] e);
    @(negedge clk);
    pfd_valid = 1'b1;
    pfd_err = e;
    @(negedge clk);
    pfd_valid = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {pfd_valid, go, pfd_err, word, err_total, n_checks} = '0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (1000) @(negedge clk);
    check(rdy, 1'b0);
    check(obs, 1'b0);
    wait_ready;
    check(obs, 1'b1);
    check(droe, 1'b1);
    check(xo, 1'b1);
    check(rpul, 1'b1);
    period(0);
    check(24'(p), 24'h10);
    check(24'(h), 24'h8);
    wr(24'h0EA000);
    check(xsel, 1'b1);
    check(xo, 1'b0);
    period(0);
    period(0);
    check(24'(p), 24'hC);
    check(24'(h), 24'h6);
    period(1);
    check(24'(p), 24'hA);
    wr(24'h002007);
    check({vco, droe, pa}, 3'h4);
    wr(24'h400001);
    check(hb, 1'b1);
    wr(24'hABCDE6);
    check(mod_q, 24'hABCDE6);
    for (int i = 0; i < 4; i++) cmp(8'h03);
    cmp(8'h0F);
    for (int i = 0; i < 4; i++) cmp(8'h03);
    check(lock, 1'b0);
    cmp(8'h03);
    check({lock, obs}, 2'h3);
    cmp(8'h18);
    check(lock, 1'b1);
    cmp(8'h19);
    check({lock, obs}, 2'h0);
    wr(24'h002803);
    check(obs, 1'b0);
    check(vco, 1'b0);
    for (int i = 0; i < 5; i++) cmp(8'h03);
    check(obs, 1'b1);
    wr(24'h001003);
    check({obs_oe, obs}, 2'h1);
    ce = 1'b0;
    repeat (3) @(negedge clk);
    check({lock, rdy, xo, vco, reg_en}, 5'h00);
    check({obs_oe, obs}, 2'h2);
    check(mod_q, 24'h800602);
    ce = 1'b1;
    wait_ready;
    check({droe, xsel, rpul}, 3'h5);
    stop_test;
  end
endmodule
